// ---- rtl/dfs_service.sv ----
// Drive fieldbus service logic: parameter mailbox, sync, emergencies, drive states.
// Assumes the mailbox framing and the object dictionary lookups live outside.
//
// Overview of operation
// (RQ1) Serve parameter requests whenever they arrive; code holds them off in init and while an abort waits to be sent.
// (RQ2) Failed transfers answer with a 32-bit abort.
// (RQ3) Toggle, timeout, unknown command get own codes.
// (RQ4) Unsupported, write-only read, read-only write aborts.
// (RQ5) Missing index and missing sub-index differ.
// (RQ6) Unmappable object and mapping limit aborts.
// (RQ7) Length mismatch, too long, too short.
// (RQ8) Range, too large, too small on writes.
// (RQ9) Maximum below minimum gets its code.
// (RQ10) General and application refusal codes.
// (RQ11) Memory range and hardware fault codes.
// (RQ12) Free run: own timer, master cycle >= 1 ms.
// (RQ13) SM2 mode: tick per output frame.
// (RQ14) DC mode: tick per SYNC0 pulse.
// (RQ15) One emergency per error occurrence.
// (RQ16) Emergency is eight bytes, fixed layout.
// (RQ17) Alarm emergency: FF00h, register, alarm code.
// (RQ18) Failed safe-op move: A000h, 02h, 0Ah.
// (RQ19) Refuse safe-op on bad cycle or mapping.
// (RQ20) No parameter writes until initialisation ends.
// (RQ21) Motor energised only in three states.
// (RQ22) Alarm: fault reaction, then fault state; code skips the reaction unless the motor runs, ignores it in not-ready.
// (RQ23) Master steers states by controlword bits.
// (RQ24) Mailbox outside init, outputs only operational.
// (RQ25) Multi-byte fields go low byte first.
module dfs_service
#(
  parameter int unsigned FREE_CYC = dfs_pkg::FREE_RUN_CYC,
  parameter int unsigned TMO_CYC  = dfs_pkg::SDO_TMO_CYC
)
(
  // Clock and reset.
  input  wire logic                core_clk,
  input  wire logic                rst,
  // Mailbox parameter requests.
  input  wire logic                reqValid,
  output logic                     reqReady,
  input  wire dfs_pkg::dfs_req_t   req,
  output logic                     respValid,
  output dfs_pkg::dfs_resp_t       resp,
  // Mailbox byte stream to the master.
  output logic                     txValid,
  output logic [7:0]               txByte,
  output logic                     txLast,
  input  wire logic                txReady,
  // Network state and synchronisation.
  input  wire dfs_pkg::dfs_esm_t   esmState,
  input  wire dfs_pkg::dfs_sync_t  syncMode,
  input  wire logic [15:0]         dcCycleUs,
  input  wire logic                rxPdoFrame,
  input  wire logic                sync0,
  output logic                     rxPdoAccept,
  output logic                     sm2Event,
  output logic                     appTick,
  // Safe-operational request.
  input  wire logic                safeOpReq,
  input  wire logic                badMapObj,
  input  wire logic                wrongDir,
  output logic                     safeOpAck,
  output logic                     safeOpRefuse,
  // Drive state machine.
  input  wire logic                initDone,
  input  wire logic [15:0]         controlword,
  input  wire logic                switchOnOk,
  input  wire logic                stopDone,
  input  wire logic                alarm,
  input  wire logic [7:0]          alarmCode,
  input  wire logic [7:0]          errorReg,
  output dfs_pkg::dfs_drv_t        driveState,
  output logic [15:0]              statusword,
  output logic                     motorOn,
  output logic                     paramWriteOk
);
  import dfs_pkg::*;

  localparam int FW = $clog2(FREE_CYC);
  localparam int TW = $clog2(TMO_CYC);

  logic          mbxOk;
  logic          reqTake;
  logic          segCmd;
  logic          initCmd;
  logic          knownCmd;
  logic          segActive;
  logic          segToggle;
  logic [TW-1:0] tmoCnt;
  logic          tmoHit;
  logic          selAbort;
  logic [31:0]   selCode;
  logic          next_abort;
  logic [31:0]   next_code;
  logic          abortPend;
  logic [31:0]   abortCode;
  logic          alarmSeen;
  logic          alarmRise;
  logic [7:0]    alarmHeld;
  logic          emAlarmPend;
  logic          emEsmPend;
  logic          txBusy;
  logic          txLoad;
  logic [63:0]   txMsg;
  logic [3:0]    txLen;
  logic          loadAlarm;
  logic          loadEsm;
  logic          loadAbort;
  logic [FW-1:0] freeCnt;
  logic          dcOk;
  logic          cwFrPrev;
  dfs_drv_t      state;
  dfs_drv_t      next_state;

  // (RQ24) Mailbox only outside init, output data only when operational.
  assign mbxOk       = (esmState != ESM_INIT);
  assign rxPdoAccept = rxPdoFrame && (esmState == ESM_OP);

  // (RQ1) Requests are taken outside init whenever no abort waits to be sent.
  assign reqReady = mbxOk && !abortPend;
  assign reqTake  = reqValid && reqReady;
  assign segCmd   = (req.cmd == CMD_DNSEG) || (req.cmd == CMD_UPSEG);
  assign initCmd  = (req.cmd == CMD_DNINIT) || (req.cmd == CMD_UPINIT);
  assign knownCmd = segCmd || initCmd || (req.cmd == CMD_ABORT);
  assign tmoHit   = segActive && !reqTake && (tmoCnt == TW'(TMO_CYC - 1));

  dfs_abort_sel u_sel
  (
    .isWrite     (req.isWrite),
    .writeLocked (!paramWriteOk),
    .chk         (req.chk),
    .abort       (selAbort),
    .code        (selCode)
  );

  always_comb
  begin
    next_abort = 1'b0;
    next_code  = 32'h0000_0000;
    // (RQ3) Unknown command, or a segment with no transfer open.
    if (!knownCmd || (segCmd && !segActive))
    begin
      next_abort = 1'b1;
      next_code  = AB_CMD;
    end
    // (RQ3) Segment toggle must alternate.
    else if (segCmd && (req.toggle != segToggle))
    begin
      next_abort = 1'b1;
      next_code  = AB_TOGGLE;
    end
    else if (initCmd)
    begin
      next_abort = selAbort;
      next_code  = selCode;
    end
  end

  // Segmented transfer tracking.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      segActive <= 1'b0;
      segToggle <= 1'b0;
    end
    else if (tmoHit)
      segActive <= 1'b0;
    else if (reqTake)
    begin
      if ((req.cmd == CMD_ABORT) || next_abort)
        segActive <= 1'b0;
      else if (initCmd)
      begin
        segActive <= req.segmented && !req.last;
        segToggle <= 1'b0;
      end
      else
      begin
        segToggle <= !segToggle;
        segActive <= !req.last;
      end
    end
  end

  // (RQ3) Protocol timeout while a segmented transfer waits.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      tmoCnt <= '0;
    else if (!segActive || reqTake || tmoHit)
      tmoCnt <= '0;
    else
      tmoCnt <= tmoCnt + TW'(1);
  end

  // (RQ2) Answer every request except an abort command, abort code when it fails.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      respValid <= 1'b0;
      resp      <= '0;
    end
    else if (tmoHit)
    begin
      respValid <= 1'b1;
      resp      <= '{abort: 1'b1, code: AB_TMO};
    end
    else
    begin
      respValid <= reqTake && (req.cmd != CMD_ABORT);
      resp      <= '{abort: next_abort, code: next_code};
    end
  end

  // Abort waiting for the mailbox sender; a new abort wins over the clear.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      abortPend <= 1'b0;
      abortCode <= 32'h0000_0000;
    end
    else if (tmoHit)
    begin
      abortPend <= 1'b1;
      abortCode <= AB_TMO;
    end
    else if (reqTake && (req.cmd != CMD_ABORT) && next_abort)
    begin
      abortPend <= 1'b1;
      abortCode <= next_code;
    end
    else if (loadAbort)
      abortPend <= 1'b0;
  end

  // (RQ15) One emergency per alarm occurrence, on its rising edge.
  assign alarmRise = alarm && !alarmSeen;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      alarmSeen   <= 1'b0;
      alarmHeld   <= 8'h00;
      emAlarmPend <= 1'b0;
    end
    else
    begin
      alarmSeen <= alarm;
      if (alarmRise)
      begin
        emAlarmPend <= 1'b1;
        alarmHeld   <= alarmCode;
      end
      else if (loadAlarm)
        emAlarmPend <= 1'b0;
    end
  end

  // (RQ19) Safe-operational check on request from pre-operational.
  always_comb
  begin
    dcOk = (dcCycleUs == DC_US_250) || (dcCycleUs == DC_US_500);
    for (int ms = 1; ms <= int'(DC_MAX_MS); ms++)
      if (dcCycleUs == 16'(ms * 1000))
        dcOk = 1'b1;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      safeOpAck    <= 1'b0;
      safeOpRefuse <= 1'b0;
      emEsmPend    <= 1'b0;
    end
    else
    begin
      safeOpAck    <= 1'b0;
      safeOpRefuse <= 1'b0;
      // A refusal in the cycle that sends an older one still wins.
      if (loadEsm)
        emEsmPend <= 1'b0;
      if (safeOpReq && (esmState == ESM_PREOP))
      begin
        if (badMapObj || wrongDir || ((syncMode == SYNC_DC) && !dcOk))
        begin
          safeOpRefuse <= 1'b1;
          emEsmPend    <= 1'b1;
        end
        else
          safeOpAck <= 1'b1;
      end
    end
  end

  // Mailbox arbiter: alarm emergency, transition emergency, then abort.
  always_comb
  begin
    loadAlarm = 1'b0;
    loadEsm   = 1'b0;
    loadAbort = 1'b0;
    txMsg     = 64'h0;
    txLen     = 4'h0;
    if (!txBusy && mbxOk)
    begin
      // (RQ16) (RQ17) Alarm layout, bytes 3 and 5 to 7 zero.
      if (emAlarmPend)
      begin
        loadAlarm = 1'b1;
        txMsg     = {24'h0, alarmHeld, 8'h00, errorReg, EM_ALARM};
        txLen     = EM_BYTES;
      end
      // (RQ18) Channel and diagnosis after the transition code.
      else if (emEsmPend)
      begin
        loadEsm = 1'b1;
        txMsg   = {32'h0, EM_DIAG, EM_CHAN, EM_ESM};
        txLen   = EM_BYTES;
      end
      else if (abortPend)
      begin
        loadAbort = 1'b1;
        txMsg     = {32'h0, abortCode};
        txLen     = AB_BYTES;
      end
    end
  end
  assign txLoad = loadAlarm || loadEsm || loadAbort;

  dfs_byte_tx u_tx
  (
    .core_clk (core_clk),
    .rst      (rst),
    .load     (txLoad),
    .msg      (txMsg),
    .len      (txLen),
    .busy     (txBusy),
    .txValid  (txValid),
    .txByte   (txByte),
    .txLast   (txLast),
    .txReady  (txReady)
  );

  // (RQ12) Free-run timer gives the application period.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      freeCnt <= '0;
    else if (freeCnt == FW'(FREE_CYC - 1))
      freeCnt <= '0;
    else
      freeCnt <= freeCnt + FW'(1);
  end

  // (RQ13) (RQ14) Application tick follows the chosen source.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      appTick  <= 1'b0;
      sm2Event <= 1'b0;
    end
    else
    begin
      sm2Event <= rxPdoAccept;
      unique case (syncMode)
        SYNC_FREE: appTick <= (freeCnt == FW'(FREE_CYC - 1));
        SYNC_SM2:  appTick <= rxPdoAccept;
        SYNC_DC:   appTick <= sync0;
        default:   appTick <= 1'b0;
      endcase
    end
  end

  // (RQ22) (RQ23) Drive state transitions from controlword and alarms.
  always_comb
  begin
    next_state = state;
    unique case (state)
      DS_NRDY:
        if (initDone) next_state = DS_SOD;
      DS_SOD:
        if (controlword[CW_QS] && controlword[CW_EV] && !controlword[CW_SO])
          next_state = DS_RDY;
      DS_RDY:
        if (!controlword[CW_EV] || !controlword[CW_QS]) next_state = DS_SOD;
        else if (controlword[CW_SO] && switchOnOk)
          next_state = controlword[CW_EO] ? DS_OPEN : DS_SWON;
      DS_SWON:
        if (!controlword[CW_EV]) next_state = DS_SOD;
        else if (!controlword[CW_QS]) next_state = DS_SOD;
        else if (!controlword[CW_SO] || !switchOnOk) next_state = DS_RDY;
        else if (controlword[CW_EO]) next_state = DS_OPEN;
      DS_OPEN:
        if (!controlword[CW_EV]) next_state = DS_SOD;
        else if (!controlword[CW_QS]) next_state = DS_QSTOP;
        else if (!controlword[CW_SO] || !switchOnOk) next_state = DS_RDY;
        else if (!controlword[CW_EO]) next_state = DS_SWON;
      DS_QSTOP:
        if (stopDone || !controlword[CW_EV]) next_state = DS_SOD;
      DS_FRA:
        if (stopDone) next_state = DS_FAULT;
      DS_FAULT:
        if (controlword[CW_FR] && !cwFrPrev && !alarm) next_state = DS_SOD;
    endcase
    // (RQ22) Alarm stops a running motor first, otherwise straight to fault; ignored in not-ready.
    if (alarm && (state != DS_NRDY) && (state != DS_FRA) && (state != DS_FAULT))
      next_state = ((state == DS_OPEN) || (state == DS_QSTOP)) ? DS_FRA : DS_FAULT;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state    <= DS_NRDY;
      cwFrPrev <= 1'b0;
    end
    else
    begin
      state    <= next_state;
      cwFrPrev <= controlword[CW_FR];
    end
  end

  assign driveState = state;
  // (RQ21) Excitation only in the three running states.
  assign motorOn = (state == DS_OPEN) || (state == DS_QSTOP) || (state == DS_FRA);
  // (RQ20) Writes refused until initialisation completes.
  assign paramWriteOk = (state != DS_NRDY);

  // (RQ22) Current state reported in the status object.
  always_comb
  begin
    unique case (state)
      DS_NRDY:  statusword = 16'h0000;
      DS_SOD:   statusword = 16'h0040;
      DS_RDY:   statusword = 16'h0021;
      DS_SWON:  statusword = 16'h0023;
      DS_OPEN:  statusword = 16'h0027;
      DS_QSTOP: statusword = 16'h0007;
      DS_FRA:   statusword = 16'h000f;
      DS_FAULT: statusword = 16'h0008;
    endcase
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_toggle_abort: assert property (reqTake && segActive && segCmd && knownCmd && // RQ3
    (req.toggle != segToggle) |=> respValid && resp.abort && (resp.code == AB_TOGGLE))
    else $error("toggle fault not aborted");
  a_timeout_abort: assert property (tmoHit |=> respValid && (resp.code == AB_TMO) // RQ3
    && abortPend) else $error("timeout not aborted");
  a_emcy_once: assert property ($rose(emAlarmPend) |-> $past(alarm && !alarmSeen)) // RQ15
    else $error("emergency raised without new alarm");
  a_motor_enable: assert property ($rose(motorOn) |-> $past(controlword[3:0] == 4'hf)) // RQ21
    else $error("motor energised without enable operation");
  a_init_lock: assert property (reqTake && (req.cmd == CMD_DNINIT) && req.isWrite && // RQ20
    (req.chk == '0) && (state == DS_NRDY) |=> resp.code == AB_DEVSTAT)
    else $error("write accepted before init done");
  a_sm2_tick: assert property (appTick && $past(syncMode == SYNC_SM2) |-> // RQ13
    $past(rxPdoFrame && (esmState == ESM_OP))) else $error("sm2 tick without frame");
  a_esm_emcy: assert property (safeOpRefuse |-> emEsmPend) // RQ18
    else $error("refused transition without emergency");
  a_alarm_lsb: assert property (loadAlarm |=> txValid && (txByte == EM_ALARM[7:0]) // RQ25
    ##0 txLast == 1'b0) else $error("alarm code not low byte first");
  a_fault_path: assert property ((state == DS_FRA) && stopDone && alarm |=> // RQ22
    state == DS_FAULT ##1 (state == DS_FAULT)) else $error("fault reaction did not end");
endmodule // dfs_service

// ---- rtl/dfs_pkg.sv ----
// Constants, types and message layouts for the drive fieldbus service logic.
// Assumes one core clock at 50 MHz; every block using it sits in that domain.
package dfs_pkg;
  localparam int unsigned CLK_HZ       = 50_000_000;
  localparam int unsigned FREE_RUN_US  = 1000;
  localparam int unsigned FREE_RUN_CYC = (CLK_HZ / 1_000_000) * FREE_RUN_US;
  localparam int unsigned SDO_TMO_MS   = 100;
  localparam int unsigned SDO_TMO_CYC  = (CLK_HZ / 1000) * SDO_TMO_MS;
  localparam int unsigned DC_MAX_MS    = 8;

  localparam logic [31:0] AB_TOGGLE  = 32'h0503_0000;
  localparam logic [31:0] AB_TMO     = 32'h0504_0000;
  localparam logic [31:0] AB_CMD     = 32'h0504_0001;
  localparam logic [31:0] AB_MEM     = 32'h0504_0005;
  localparam logic [31:0] AB_UNSUPP  = 32'h0601_0000;
  localparam logic [31:0] AB_WRONLY  = 32'h0601_0001;
  localparam logic [31:0] AB_RDONLY  = 32'h0601_0002;
  localparam logic [31:0] AB_NOOBJ   = 32'h0602_0000;
  localparam logic [31:0] AB_NOMAP   = 32'h0604_0041;
  localparam logic [31:0] AB_MAPLIM  = 32'h0604_0042;
  localparam logic [31:0] AB_HWERR   = 32'h0606_0000;
  localparam logic [31:0] AB_LEN     = 32'h0607_0010;
  localparam logic [31:0] AB_LENLONG = 32'h0607_0012;
  localparam logic [31:0] AB_LENSHRT = 32'h0607_0013;
  localparam logic [31:0] AB_NOSUB   = 32'h0609_0011;
  localparam logic [31:0] AB_RANGE   = 32'h0609_0030;
  localparam logic [31:0] AB_TOOBIG  = 32'h0609_0031;
  localparam logic [31:0] AB_TOOSML  = 32'h0609_0032;
  localparam logic [31:0] AB_MAXMIN  = 32'h0609_0036;
  localparam logic [31:0] AB_GENERAL = 32'h0800_0000;
  localparam logic [31:0] AB_XFER    = 32'h0800_0020;
  localparam logic [31:0] AB_LOCAL   = 32'h0800_0021;
  localparam logic [31:0] AB_DEVSTAT = 32'h0800_0022;

  localparam logic [15:0] EM_ALARM = 16'hff00;
  localparam logic [15:0] EM_ESM   = 16'ha000;
  localparam logic [7:0]  EM_CHAN  = 8'h02;
  localparam logic [7:0]  EM_DIAG  = 8'h0a;
  localparam logic [3:0]  EM_BYTES = 4'h8;
  localparam logic [3:0]  AB_BYTES = 4'h4;

  localparam logic [15:0] DC_US_250 = 16'h00fa;
  localparam logic [15:0] DC_US_500 = 16'h01f4;

  localparam logic [2:0] CMD_DNSEG  = 3'h0;
  localparam logic [2:0] CMD_DNINIT = 3'h1;
  localparam logic [2:0] CMD_UPINIT = 3'h2;
  localparam logic [2:0] CMD_UPSEG  = 3'h3;
  localparam logic [2:0] CMD_ABORT  = 3'h4;

  localparam int unsigned CW_SO = 0;
  localparam int unsigned CW_EV = 1;
  localparam int unsigned CW_QS = 2;
  localparam int unsigned CW_EO = 3;
  localparam int unsigned CW_FR = 7;

  typedef enum logic [1:0] {
    ESM_INIT = 2'h0, ESM_PREOP = 2'h1, ESM_SAFEOP = 2'h2, ESM_OP = 2'h3
  } dfs_esm_t;
  typedef enum logic [1:0] {
    SYNC_FREE = 2'h0, SYNC_SM2 = 2'h1, SYNC_DC = 2'h2, SYNC_RSVD = 2'h3
  } dfs_sync_t;
  typedef enum logic [2:0] {
    DS_NRDY = 3'b000, DS_SOD = 3'b001, DS_RDY = 3'b011, DS_SWON = 3'b010,
    DS_OPEN = 3'b110, DS_QSTOP = 3'b111, DS_FRA = 3'b101, DS_FAULT = 3'b100
  } dfs_drv_t;

  typedef struct packed {
    logic noObj;    logic noSub;    logic unsupp;   logic wrOnly;
    logic rdOnly;   logic noMap;    logic mapLim;   logic lenBad;
    logic lenLong;  logic lenShort; logic rangeOut; logic tooBig;
    logic tooSmall; logic maxMin;   logic memRange; logic hwFault;
    logic xferFail; logic localCtl; logic general;
  } dfs_chk_t;
  typedef struct packed {
    logic [2:0] cmd;
    logic       toggle;
    logic       last;
    logic       segmented;
    logic       isWrite;
    dfs_chk_t   chk;
  } dfs_req_t;
  typedef struct packed {
    logic        abort;
    logic [31:0] code;
  } dfs_resp_t;
endpackage

// ---- rtl/dfs_abort_sel.sv ----
// Picks the abort code for a checked parameter request, most specific first.
// Assumes the object checks are already decoded into flags by the caller.
module dfs_abort_sel
(
  // Checked request.
  input  wire logic             isWrite,
  input  wire logic             writeLocked,
  input  wire dfs_pkg::dfs_chk_t chk,
  // Verdict.
  output logic                  abort,
  output logic [31:0]           code
);
  import dfs_pkg::*;

  always_comb
  begin
    abort = 1'b1;
    code  = 32'h0000_0000;
    // (RQ5) Dictionary lookup.
    if (chk.noObj) code = AB_NOOBJ;
    else if (chk.noSub) code = AB_NOSUB;
    // (RQ4) Access direction.
    else if (chk.unsupp) code = AB_UNSUPP;
    else if (!isWrite && chk.wrOnly) code = AB_WRONLY;
    else if (isWrite && chk.rdOnly) code = AB_RDONLY;
    // (RQ6) Mapping limits.
    else if (isWrite && chk.noMap) code = AB_NOMAP;
    else if (isWrite && chk.mapLim) code = AB_MAPLIM;
    // (RQ7) Length against data type.
    else if (chk.lenLong) code = AB_LENLONG;
    else if (chk.lenShort) code = AB_LENSHRT;
    else if (chk.lenBad) code = AB_LEN;
    // (RQ8) Value range on writes.
    else if (isWrite && chk.tooBig) code = AB_TOOBIG;
    else if (isWrite && chk.tooSmall) code = AB_TOOSML;
    else if (isWrite && chk.rangeOut) code = AB_RANGE;
    // (RQ9) Limit pair ordering.
    else if (isWrite && chk.maxMin) code = AB_MAXMIN;
    // (RQ11) Memory range and hardware fault.
    else if (chk.memRange) code = AB_MEM;
    else if (chk.hwFault) code = AB_HWERR;
    // (RQ10) Application refuses the data.
    else if (isWrite && writeLocked) code = AB_DEVSTAT;
    else if (chk.localCtl) code = AB_LOCAL;
    else if (chk.xferFail) code = AB_XFER;
    else if (chk.general) code = AB_GENERAL;
    else abort = 1'b0;
  end
endmodule // dfs_abort_sel

// ---- rtl/dfs_byte_tx.sv ----
// Mailbox byte sender: shifts a loaded message out, byte 0 first.
// Assumes the mailbox sink may stall with txReady low for any time.
module dfs_byte_tx
(
  // Clock and reset.
  input  wire logic        core_clk,
  input  wire logic        rst,
  // Message load.
  input  wire logic        load,
  input  wire logic [63:0] msg,
  input  wire logic [3:0]  len,
  output logic             busy,
  // Byte stream.
  output logic             txValid,
  output logic [7:0]       txByte,
  output logic             txLast,
  input  wire logic        txReady
);
  import dfs_pkg::*;

  logic [63:0] shiftReg;
  logic [3:0]  left;

  assign busy    = (left != 4'h0);
  assign txValid = busy;
  assign txByte  = shiftReg[7:0];
  assign txLast  = (left == 4'h1);

  // (RQ25) Low byte leaves first.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      shiftReg <= 64'h0;
      left     <= 4'h0;
    end
    else if (load && !busy)
    begin
      shiftReg <= msg;
      left     <= len;
    end
    else if (txValid && txReady)
    begin
      shiftReg <= {8'h00, shiftReg[63:8]};
      left     <= left - 4'h1;
    end
  end
endmodule // dfs_byte_tx

// ---- verification/dfs_master_model.sv ----
// Master mailbox sink; stalls on every other cycle when slow is high.
// Assumes the device sends bytes low first, so each new byte enters at the top.
module dfs_master_model
(
  // Clock and reset.
  input  wire logic       core_clk,
  input  wire logic       rst,
  // Pacing.
  input  wire logic       slow,
  // Byte stream.
  input  wire logic       txValid,
  input  wire logic [7:0] txByte,
  input  wire logic       txLast,
  output logic            txReady,
  output logic [63:0]     msg,
  output int              cnt,
  output int              lastCnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ph;
  assign txReady = !slow || ph;
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      ph  <= 1'b0;
      msg <= '0;
      cnt <= 0;
      lastCnt <= 0;
    end
    else
    begin
      ph <= ~ph;
      if (txValid && txReady)
      begin
        msg <= {txByte, msg[63:8]};
        cnt <= cnt + 1;
        if (txLast)
          lastCnt <= cnt + 1;
      end
    end
  end
endmodule // dfs_master_model

// ---- verification/dfs_service_tb.sv ----
// Bench for the drive service logic; a master model sinks the mailbox bytes.
module dfs_service_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import dfs_pkg::*;
  logic core_clk = 0, rst = 1, reqValid = 0, slow = 1, reqReady, respValid, txValid, txLast;
  logic txReady, rxPdoFrame = 0, sync0 = 0, rxPdoAccept, sm2Event, appTick, safeOpReq = 0;
  logic badMapObj = 1, wrongDir = 0, safeOpAck, safeOpRefuse, initDone = 0, switchOnOk = 1;
  logic stopDone = 0, alarm = 0, motorOn, paramWriteOk;
  logic [7:0] txByte, alarmCode = 8'h30, errorReg = 8'h05;
  logic [15:0] dcCycleUs = 16'h01f4, controlword = 16'h0000, statusword;
  logic [63:0] msg;
  dfs_req_t req = '0;
  dfs_resp_t resp;
  dfs_esm_t esmState = ESM_INIT;
  dfs_sync_t syncMode = SYNC_DC;
  dfs_drv_t driveState;
  int cnt, lastCnt, b, n, err_count = 0, total_checks = 0, cyc = 0;
  logic [31:0] ab [19] = '{AB_NOOBJ, AB_NOSUB, AB_UNSUPP, AB_WRONLY, AB_RDONLY, AB_NOMAP,
    AB_MAPLIM, AB_LEN, AB_LENLONG, AB_LENSHRT, AB_RANGE, AB_TOOBIG, AB_TOOSML, AB_MAXMIN,
    AB_MEM, AB_HWERR, AB_XFER, AB_LOCAL, AB_GENERAL};
  dfs_service #(.FREE_CYC(20), .TMO_CYC(50)) DUT (.core_clk, .rst, .reqValid, .reqReady, .req,
    .respValid, .resp, .txValid, .txByte, .txLast, .txReady, .esmState, .syncMode, .dcCycleUs,
    .rxPdoFrame, .sync0, .rxPdoAccept, .sm2Event, .appTick, .safeOpReq, .badMapObj, .wrongDir,
    .safeOpAck, .safeOpRefuse, .initDone, .controlword, .switchOnOk, .stopDone, .alarm,
    .alarmCode, .errorReg, .driveState, .statusword, .motorOn, .paramWriteOk);
  dfs_master_model MST (.core_clk, .rst, .slow, .txValid, .txByte, .txLast, .txReady, .msg,
    .cnt, .lastCnt);
  always #10 core_clk = ~core_clk;
  task automatic stop_test();
    if (err_count == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      stop_test();
    end
  end
  task automatic cmp(input logic [63:0] g, e);
    total_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("wrong value at %0t: %h vs %h", $time, g, e);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  // Waits, bounded, until k bytes past the mark b have reached the master.
  task automatic getn(input int k);
    for (int i = 0; i < 300 && cnt < b + k; i++) tick(1);
  endtask
  task automatic sdo(input logic [2:0] cm, input logic sg, tg, input dfs_chk_t c,
                     input logic [32:0] e);
    for (int i = 0; i < 20 && (i == 0 || !reqReady); i++) tick(1);
    b = cnt;
    req = '{cmd: cm, toggle: tg, last: !sg, segmented: sg, isWrite: c != 19'h08000, chk: c};
    reqValid = 1'b1;
    tick(1);
    reqValid = 1'b0;
    if (!respValid) tick(1);
    cmp({respValid, reqReady, resp.abort, e[32] ? resp.code : 32'h0}, {1'b1, !e[32], e});
    getn(e[32] ? 4 : 0);
    cmp({e[32] ? msg[63:32] : 32'h0, lastCnt}, {e[31:0], cnt});
  endtask
  task automatic sop(input logic [1:0] e);
    b = cnt;
    safeOpReq = 1'b1;
    tick(1);
    safeOpReq = 1'b0;
    if (!(safeOpRefuse || safeOpAck)) tick(1);
    cmp({safeOpRefuse, safeOpAck}, e);
  endtask
  initial
  begin
    tick(5);
    rst = 1'b0;
    cmp({statusword, motorOn, paramWriteOk, reqReady}, 19'h0);
    esmState = ESM_PREOP;
    sdo(CMD_DNINIT, 0, 0, '0, {1'b1, AB_DEVSTAT});
    initDone = 1'b1;
    tick(2);
    cmp({statusword, paramWriteOk}, {16'h0040, 1'b1});
    for (int i = 0; i < 19; i++) sdo(CMD_DNINIT, 0, 0, 19'h40000 >> i, {1'b1, ab[i]});
    sdo(CMD_UPINIT, 0, 0, '0, 33'h0);
    sdo(3'h5, 0, 0, '0, {1'b1, AB_CMD});
    sdo(CMD_UPSEG, 1, 0, '0, {1'b1, AB_CMD});
    sdo(CMD_DNINIT, 1, 0, '0, 33'h0);
    sdo(CMD_DNSEG, 1, 0, '0, 33'h0);
    sdo(CMD_DNSEG, 1, 0, '0, {1'b1, AB_TOGGLE});
    sdo(CMD_DNINIT, 1, 0, '0, 33'h0);
    tick(1);
    b = cnt;
    for (int i = 0; i < 80 && !respValid; i++) tick(1);
    cmp({respValid, resp}, {2'b11, AB_TMO});
    getn(4);
    cmp(msg[63:32], AB_TMO);
    sop(2'b10);
    getn(8);
    cmp(msg, 64'h0000_0000_0a02_a000);
    badMapObj = 1'b0;
    wrongDir = 1'b1;
    sop(2'b10);
    getn(8);
    wrongDir = 1'b0;
    dcCycleUs = 16'h012c;
    sop(2'b10);
    getn(8);
    cmp(lastCnt, b + 8);
    dcCycleUs = 16'h1f40;
    sop(2'b01);
    rxPdoFrame = 1'b1;
    #1 cmp(rxPdoAccept, 1'b0);
    rxPdoFrame = 1'b0;
    esmState = ESM_OP;
    sync0 = 1'b1;
    tick(1);
    cmp(appTick, 1'b1);
    syncMode = SYNC_RSVD;
    tick(1);
    sync0 = 1'b0;
    cmp(appTick, 1'b0);
    syncMode = SYNC_SM2;
    rxPdoFrame = 1'b1;
    #1 cmp(rxPdoAccept, 1'b1);
    tick(1);
    rxPdoFrame = 1'b0;
    cmp({sm2Event, appTick}, 2'b11);
    syncMode = SYNC_FREE;
    n = 0;
    for (int i = 0; i < 100; i++)
    begin
      tick(1);
      n += appTick;
    end
    cmp(n, 5);
    controlword = 16'h0006;
    tick(2);
    controlword = 16'h0007;
    tick(2);
    controlword = 16'h000f;
    tick(2);
    cmp({statusword, motorOn, driveState}, {16'h0027, 1'b1, DS_OPEN});
    b = cnt;
    alarm = 1'b1;
    tick(2);
    cmp({statusword, motorOn}, {16'h000f, 1'b1});
    getn(8);
    cmp(msg, {24'h0, alarmCode, 8'h0, errorReg, 16'hff00});
    stopDone = 1'b1;
    tick(2);
    cmp({statusword, motorOn}, {16'h0008, 1'b0});
    b = cnt;
    tick(30);
    cmp(cnt, b);
    alarm = 1'b0;
    controlword = 16'h0080;
    tick(2);
    cmp({statusword, driveState}, {16'h0040, DS_SOD});
    stop_test();
  end
endmodule // dfs_service_tb
